// ==== tio_pkg.sv ====
// constants and types for the timed i/o port unit
package tio_pkg;

    // ==========================================================
    // sizes
    localparam int NPORT  = 6;
    localparam int NCB    = 6;
    localparam int NPIN   = 32;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int LEFT_W = 6;
    localparam int DIV_W  = 8;
    localparam int ADDR_W = 9;

    // port widths in priority order, narrowest first, and first pin
    localparam int PORT_W    [NPORT] = '{1, 1, 4, 8, 16, 32};
    localparam int PORT_BASE [NPORT] = '{0, 1, 0, 0, 0, 0};

    // pins claimed by the serial link when it is enabled
    localparam int LINK_LO = 24;
    localparam int LINK_HI = 31;

    // ==========================================================
    // register map
    localparam logic [4:0] OFS_CTRL  = 5'h00;
    localparam logic [4:0] OFS_DATA  = 5'h04;
    localparam logic [4:0] OFS_TIME  = 5'h08;
    localparam logic [4:0] OFS_COUNT = 5'h0c;
    localparam logic [4:0] OFS_STAMP = 5'h10;
    localparam logic [4:0] OFS_COND  = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_CB_BASE = 9'h100;
    localparam logic [ADDR_W-1:0] OFS_LINK    = 9'h140;

    // ==========================================================
    // control and status fields
    localparam int CTRL_EN     = 0;
    localparam int CTRL_OUT    = 1;
    localparam int CTRL_OC     = 2;
    localparam int CTRL_STB    = 3;
    localparam int CTRL_TIMED  = 4;
    localparam int CTRL_COND   = 5;
    localparam int CTRL_CB     = 8;
    localparam int STAT_BUSY   = 16;
    localparam int STAT_VALID  = 17;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_077f;

    localparam int CB_SRC    = 0;
    localparam int CB_DIV    = 8;
    localparam logic [DIV_W-1:0] CB_DIV_RESET = 8'h00;

    localparam logic [1:0] COND_NONE = 2'h0;
    localparam logic [1:0] COND_EQ   = 2'h1;
    localparam logic [1:0] COND_NE   = 2'h2;

    typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} port_state_e;

endpackage : tio_pkg

// ==== cb_if.sv ====
// configuration and tick carrier between the port unit and one clock block
`timescale 1ns/1ps
interface cb_if;
    logic [7:0] div;
    logic       src_pin;
    logic       tick;

    modport cfg (output div, output src_pin, input tick);
    modport blk (input div, input src_pin, output tick);
endinterface : cb_if

// ==== clock_block.sv ====
// one programmable clock block: reference or pin source, optional divide
`timescale 1ns/1ps
module clock_block (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic ce,
    input  wire logic ext_rise,
    cb_if.blk         cb
);
    logic [tio_pkg::DIV_W-1:0] dcnt;
    logic                      src_ev;

    assign src_ev  = cb.src_pin ? ext_rise : 1'b1;
    assign cb.tick = ce & src_ev & (dcnt == cb.div);

    // divider: one tick per div+1 source events
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dcnt <= 8'h00;
        end else if (ce && src_ev) begin
            dcnt <= (dcnt == cb.div) ? 8'h00 : dcnt + 8'h01;
        end
    end
endmodule : clock_block

// ==== timed_io_port.sv ====
// timed i/o port unit: six ports, six clock blocks, pin sharing, bus slave
//
// What this block does
// - each port has one direction bit, all its pins in or out
// - ports of one, four, eight, sixteen and thirty-two bits on pins
// - open-collector: zero pulls low, one releases the pin
// - ports drive or sample pins; sampling can wait for a pin condition
// - every bus access answers within one wait cycle at most
// - input words pass through a shift register and a transfer register
// - sixteen-bit port counter can gate when data moves
// - counter readable anytime; transfers can wait for a programmed count
// - counter is captured as a timestamp on each transfer
// - enabled link takes its pins away from every port
// - narrower enabled port wins shared pins; other pins stay with wider
// - ports always shift at their nominal width despite lost pins
// - six clock blocks; block 0 runs from the reference by default
// - a clock block may take the 1-bit port pin as source, divided
// - strobe in qualifies input; strobe out accompanies output data
// - after reset every port uses clock block 0
// - pin conditions and completed words raise direct event pulses
`timescale 1ns/1ps
module timed_io_port (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic [8:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output wire logic        waitrequest,
    input  wire logic [31:0] pad_in,
    output wire logic [31:0] pad_out,
    output wire logic [31:0] pad_oe,
    input  wire logic [5:0]  strobe_in,
    output wire logic [5:0]  strobe_out,
    output wire logic [5:0]  port_event,
    output logic             link_en
);
    localparam int NPORT  = tio_pkg::NPORT;
    localparam int NCB    = tio_pkg::NCB;
    localparam int NPIN   = tio_pkg::NPIN;
    localparam int DATA_W = tio_pkg::DATA_W;
    localparam int CNT_W  = tio_pkg::CNT_W;
    localparam int LEFT_W = tio_pkg::LEFT_W;

    // ==========================================================
    // input synchronisers
    logic [NPIN-1:0]  pad_m;
    logic [NPIN-1:0]  pad_s;
    logic [NPIN-1:0]  pad_d;
    logic [NPORT-1:0] stb_m;
    logic [NPORT-1:0] stb_s;

    // pins and strobes come from outside, two flops before any use
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pad_m <= 32'h0000_0000;
            pad_s <= 32'h0000_0000;
            pad_d <= 32'h0000_0000;
            stb_m <= 6'h00;
            stb_s <= 6'h00;
        end else if (ce) begin
            pad_m <= pad_in;
            pad_s <= pad_m;
            pad_d <= pad_s;
            stb_m <= strobe_in;
            stb_s <= stb_m;
        end
    end

    // rising edge on the 1-bit port pin feeds clock block sources
    logic ext_rise;
    assign ext_rise = pad_s[tio_pkg::PORT_BASE[0]] & ~pad_d[tio_pkg::PORT_BASE[0]];

    // ==========================================================
    // bus decode
    logic [31:0] rd_mux;
    logic        rd_done;
    logic        rd_take;
    logic        in_cb_area;
    logic [2:0]  bus_port;
    logic [4:0]  bus_reg;
    logic [31:0] bmask;

    assign in_cb_area = address[8];
    assign bus_port   = address[7:5];
    assign bus_reg    = address[4:0];
    assign bmask      = {{8{byteenable[3]}}, {8{byteenable[2]}},
                         {8{byteenable[1]}}, {8{byteenable[0]}}};
    // reads wait one cycle, writes none
    assign waitrequest = read & ~rd_done;
    assign rd_take     = read & rd_done;

    // read data registered; the wait cycle hides the mux
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_done  <= 1'b0;
            readdata <= 32'h0000_0000;
        end else if (ce) begin
            rd_done <= read & ~rd_done;
            if (read && !rd_done) begin
                readdata <= rd_mux;
            end
        end
    end

    // ==========================================================
    // clock blocks
    logic [7:0]               cb_tick;
    logic [tio_pkg::DIV_W-1:0] cb_div [NCB];
    logic [NCB-1:0]            cb_src;
    logic [31:0]               cb_rd  [NCB];

    assign cb_tick[7:NCB] = 2'h0;

    // six blocks, block 0 from the reference by default
    for (genvar k = 0; k < NCB; k++) begin : g_cb
        logic cb_wr;
        cb_if cbi ();

        assign cbi.div     = cb_div[k];
        assign cbi.src_pin = cb_src[k];
        assign cb_tick[k]  = cbi.tick;
        assign cb_wr       = write & in_cb_area & (address[7:6] == 2'h0)
                           & (address[4:2] == 3'(k));
        assign cb_rd[k]    = (32'(cb_div[k]) << tio_pkg::CB_DIV)
                           | (32'(cb_src[k]) << tio_pkg::CB_SRC);

        clock_block u_cb (
            .mclk     (mclk),
            .reset_n  (reset_n),
            .ce       (ce),
            .ext_rise (ext_rise),
            .cb       (cbi.blk)
        );

        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                cb_div[k] <= tio_pkg::CB_DIV_RESET;
                cb_src[k] <= 1'b0;
            end else if (ce && cb_wr) begin
                if (byteenable[1]) cb_div[k] <= writedata[tio_pkg::CB_DIV +: tio_pkg::DIV_W];
                if (byteenable[0]) cb_src[k] <= writedata[tio_pkg::CB_SRC];
            end
        end
    end

    // link enable register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            link_en <= 1'b0;
        end else if (ce && write && address == tio_pkg::OFS_LINK && byteenable[0]) begin
            link_en <= writedata[0];
        end
    end

    // ==========================================================
    // ports
    logic [NPIN-1:0]  pdrv [NPORT];
    logic [NPIN-1:0]  pcov [NPORT];
    logic [NPORT-1:0] pen;
    logic [NPORT-1:0] pdir;
    logic [NPORT-1:0] poc;
    logic [31:0]      prd  [NPORT];

    // one instance of the port logic per entry of the width table
    for (genvar i = 0; i < NPORT; i++) begin : g_port
        localparam int W   = tio_pkg::PORT_W[i];
        localparam int B   = tio_pkg::PORT_BASE[i];
        localparam int NSH = DATA_W / W;

        logic [31:0]       ctrl;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  tmatch;
        logic [CNT_W-1:0]  stamp;
        logic [31:0]       cond_val;
        logic [31:0]       shreg;
        logic [31:0]       xfer;
        logic [LEFT_W-1:0] left;
        logic              rx_valid;
        logic              stb_q;
        logic              evt;
        logic [W-1:0]      out_val;
        tio_pkg::port_state_e state;

        logic [W-1:0]  pin_val;
        logic [1:0]    cmode;
        logic [2:0]    cbsel;
        logic          tick;
        logic          time_ok;
        logic          cond_hit;
        logic          cond_ok;
        logic          stb_ok;
        logic          sel;
        logic          first;
        logic          start_in;
        logic          step_in;
        logic          step_out;
        logic          in_done;
        logic          load_out;
        logic [31:0]   next_shreg;

        // sampling always spans the nominal width
        assign pin_val  = pad_s[B +: W];
        assign cmode    = ctrl[tio_pkg::CTRL_COND +: 2];
        assign cbsel    = ctrl[tio_pkg::CTRL_CB +: 3];
        assign tick     = cb_tick[cbsel];
        assign sel      = ~in_cb_area & (bus_port == 3'(i));
        assign first    = (left == LEFT_W'(NSH));
        assign time_ok  = ~ctrl[tio_pkg::CTRL_TIMED] | (cnt == tmatch);
        assign cond_hit = (pin_val == cond_val[W-1:0]);
        assign cond_ok  = (cmode == tio_pkg::COND_NONE)
                        | ((cmode == tio_pkg::COND_EQ) & cond_hit)
                        | ((cmode == tio_pkg::COND_NE) & ~cond_hit);
        assign stb_ok   = ~ctrl[tio_pkg::CTRL_STB] | stb_s[i];
        // direction bit selects in or out for the whole port
        assign start_in = (state == tio_pkg::ST_IDLE) & ctrl[tio_pkg::CTRL_EN]
                        & ~ctrl[tio_pkg::CTRL_OUT] & tick & time_ok & cond_ok & stb_ok;
        assign step_in  = (state == tio_pkg::ST_SHIFT) & ~ctrl[tio_pkg::CTRL_OUT]
                        & tick & stb_ok;
        // first output shift held until the count matches
        assign step_out = (state == tio_pkg::ST_SHIFT) & ctrl[tio_pkg::CTRL_OUT]
                        & tick & (~first | time_ok);
        assign in_done  = (start_in & (NSH == 1)) | (step_in & (left == 6'h01));
        assign load_out = write & sel & (bus_reg == tio_pkg::OFS_DATA)
                        & (state == tio_pkg::ST_IDLE) & ctrl[tio_pkg::CTRL_EN]
                        & ctrl[tio_pkg::CTRL_OUT];
        // deserialise narrow samples into the top of the word
        assign next_shreg = (shreg >> W) | (DATA_W'(pin_val) << (DATA_W - W));

        // configuration; writes ignore status bits
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                ctrl     <= tio_pkg::CTRL_RESET;
                tmatch   <= 16'h0000;
                cond_val <= 32'h0000_0000;
            end else if (ce && write && sel) begin
                if (bus_reg == tio_pkg::OFS_CTRL)
                    ctrl <= (ctrl & ~(bmask & tio_pkg::CTRL_WMASK))
                          | (writedata & bmask & tio_pkg::CTRL_WMASK);
                if (bus_reg == tio_pkg::OFS_TIME)
                    tmatch <= (tmatch & ~bmask[15:0]) | (writedata[15:0] & bmask[15:0]);
                if (bus_reg == tio_pkg::OFS_COND)
                    cond_val <= (cond_val & ~bmask) | (writedata & bmask);
            end
        end

        // counter steps on its clock block tick and wraps
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                cnt <= 16'h0000;
            end else if (ce && tick) begin
                cnt <= cnt + 16'h0001;
            end
        end

        // shift engine for both directions
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                state   <= tio_pkg::ST_IDLE;
                shreg   <= 32'h0000_0000;
                left    <= 6'h00;
                out_val <= '0;
                stamp   <= 16'h0000;
                xfer    <= 32'h0000_0000;
            end else if (ce) begin
                if (load_out) begin
                    shreg <= writedata;
                    left  <= LEFT_W'(NSH);
                    state <= tio_pkg::ST_SHIFT;
                end else if (step_out) begin
                    if (first) stamp <= cnt;
                    out_val <= shreg[W-1:0];
                    shreg   <= shreg >> W;
                    left    <= left - 6'h01;
                    if (left == 6'h01) state <= tio_pkg::ST_IDLE;
                end else if (start_in || step_in) begin
                    if (start_in) stamp <= cnt;
                    shreg <= next_shreg;
                    left  <= start_in ? LEFT_W'(NSH - 1) : left - 6'h01;
                    if (in_done) begin
                        xfer  <= next_shreg;
                        state <= tio_pkg::ST_IDLE;
                    end else begin
                        state <= tio_pkg::ST_SHIFT;
                    end
                end
            end
        end

        // valid flag: a new word wins over the read that clears it
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                rx_valid <= 1'b0;
                stb_q    <= 1'b0;
                evt      <= 1'b0;
            end else if (ce) begin
                if (in_done)
                    rx_valid <= 1'b1;
                else if (rd_take && sel && bus_reg == tio_pkg::OFS_DATA)
                    rx_valid <= 1'b0;
                // strobe out with each output shift
                stb_q <= step_out & ctrl[tio_pkg::CTRL_STB];
                // event on word done or condition start
                evt   <= in_done | (step_out & (left == 6'h01))
                       | (start_in & (cmode != tio_pkg::COND_NONE));
            end
        end

        assign strobe_out[i] = stb_q;
        assign port_event[i] = evt;
        assign pen[i]  = ctrl[tio_pkg::CTRL_EN];
        assign pdir[i] = ctrl[tio_pkg::CTRL_OUT];
        assign poc[i]  = ctrl[tio_pkg::CTRL_OC];
        assign pdrv[i] = NPIN'(out_val) << B;
        assign pcov[i] = NPIN'({W{1'b1}}) << B;

        // register read view
        assign prd[i] = (bus_reg == tio_pkg::OFS_CTRL)
                            ? (ctrl | (32'(state == tio_pkg::ST_SHIFT) << tio_pkg::STAT_BUSY)
                                    | (32'(rx_valid) << tio_pkg::STAT_VALID))
                      : (bus_reg == tio_pkg::OFS_DATA)  ? xfer
                      : (bus_reg == tio_pkg::OFS_TIME)  ? 32'(tmatch)
                      : (bus_reg == tio_pkg::OFS_COUNT) ? 32'(cnt)
                      : (bus_reg == tio_pkg::OFS_STAMP) ? 32'(stamp)
                      : (bus_reg == tio_pkg::OFS_COND)  ? cond_val
                      : 32'h0000_0000;
    end

    // ==========================================================
    // pin arbitration
    for (genvar j = 0; j < NPIN; j++) begin : g_pin
        logic own_out;
        logic own_oe;
        logic taken;
        logic link_pin;

        assign link_pin = link_en & (j >= tio_pkg::LINK_LO) & (j <= tio_pkg::LINK_HI);

        // narrowest enabled port first; table is in width order
        always_comb begin
            own_out = 1'b0;
            own_oe  = 1'b0;
            taken   = 1'b0;
            for (int k = 0; k < NPORT; k++) begin
                if (!taken && pen[k] && pcov[k][j]) begin
                    taken   = 1'b1;
                    own_out = poc[k] ? 1'b0 : pdrv[k][j];
                    own_oe  = pdir[k] & (~poc[k] | ~pdrv[k][j]);
                end
            end
        end

        // link pins are released by every port
        assign pad_out[j] = link_pin ? 1'b0 : own_out;
        assign pad_oe[j]  = link_pin ? 1'b0 : own_oe;
    end

    // ==========================================================
    // read selection
    logic [31:0] cb_area_rd;
    assign cb_area_rd = (address == tio_pkg::OFS_LINK) ? 32'(link_en)
                      : ((address[7:6] == 2'h0) && (32'(address[4:2]) < NCB))
                          ? cb_rd[address[4:2]]
                      : 32'h0000_0000;
    assign rd_mux = in_cb_area ? cb_area_rd
                  : (32'(bus_port) < NPORT) ? prd[bus_port]
                  : 32'h0000_0000;
endmodule : timed_io_port

// ==== tio_monitor.sv ====
// port-level checker for the timed i/o port unit
`timescale 1ns/1ps
module tio_monitor (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        ce,
    input wire logic [8:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [31:0] pad_in,
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    input wire logic [5:0]  strobe_in,
    input wire logic [5:0]  strobe_out,
    input wire logic [5:0]  port_event,
    input wire logic        link_en
);
    // ========================================
    // bus handshake
    default clocking cb_mon @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_read_wait;
        $rose(read) |-> waitrequest ##1 !waitrequest;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read did not answer after one wait cycle");
    property p_write_nowait;
        write |-> !waitrequest;
    endproperty
    a_write_nowait: assert property (p_write_nowait)
        else $error("write was held off");
    property p_wait_cause;
        waitrequest |-> read;
    endproperty
    a_wait_cause: assert property (p_wait_cause)
        else $error("wait raised without a read");
    // read data stands until the next read
    property p_rdata_hold;
        !read |=> $stable(readdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");

    // ========================================
    // pins and events
    property p_link_pins;
        link_en |-> pad_oe[31:24] == 8'h00;
    endproperty
    a_link_pins: assert property (p_link_pins)
        else $error("port drives a pin owned by the link");
    // checked inside reset too, so no disable here
    property p_reset_quiet;
        disable iff (1'b0) !reset_n |-> pad_oe == 32'h0 && port_event == 6'h00;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("pins driven or event raised in reset");
    property p_event_pulse;
        port_event[0] |=> !port_event[0];
    endproperty
    a_event_pulse: assert property (p_event_pulse)
        else $error("event longer than one cycle");
    property p_freeze;
        !ce |=> $stable(pad_out) && $stable(link_en);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    c_read: cover property (read && !waitrequest);
    c_event: cover property (port_event[2]);
    c_link: cover property (link_en);
endmodule : tio_monitor

// ==== tio_pins_model.sv ====
// external hardware on the pins: its own drive wherever the port releases a pin
`timescale 1ns/1ps
module tio_pins_model (
    input  wire logic [31:0] pad_out,
    input  wire logic [31:0] pad_oe,
    input  wire logic [31:0] drv,
    output wire logic [31:0] pad_in
);
    // released pins follow the external drive drv
    // undriven pins read drv, never the last value
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv);
endmodule : tio_pins_model

// ==== timed_io_port_test.sv ====
// self-checking bench for the timed i/o port unit
`timescale 1ns/1ps
module timed_io_port_test;
    logic        mclk = 0, reset_n = 1, ce = 1, read = 0, write = 0, ev;
    logic [8:0]  address = 9'h000;
    logic [31:0] writedata = 32'h0, readdata, pad_in, pad_out, pad_oe, q;
    logic [31:0] drv = 32'h0;
    logic [5:0]  strobe_in = 6'h00, strobe_out, port_event;
    logic        waitrequest, link_en;
    int          err_count = 0, comparisons = 0, cycles = 0;

    // ========================================
    // clock, design, pins
    always #50 mclk = ~mclk;
    timed_io_port i_timed_io_port (.mclk(mclk), .reset_n(reset_n), .ce(ce),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .strobe_in(strobe_in),
        .strobe_out(strobe_out), .port_event(port_event), .link_en(link_en));
    tio_pins_model i_tio_pins_model (.pad_out(pad_out), .pad_oe(pad_oe), .drv(drv),
        .pad_in(pad_in));

    // hang guard, well above the few hundred cycles needed
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            end_of_test();
        end
    end

    // ========================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one bus cycle; no fixed latency assumed
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk);
        address   <= a;
        writedata <= d;
        read      <= ~wr;
        write     <= wr;
        // hold everything until the edge that sees waitrequest low
        do @(posedge mclk); while (waitrequest);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    // stops at the first event or after n cycles
    task automatic wait_ev(input int p, input int n);
        ev = 1'b0;
        for (int k = 0; k < n && !ev; k++) begin
            @(negedge mclk);
            ev = port_event[p];
        end
    endtask : wait_ev

    // ========================================
    // scenarios
    task automatic t_reset;
        for (int i = 0; i < 6; i++) begin
            rd(9'(i * 32), 32'h0);
            rd(9'(256 + 4 * i), 32'h0);
        end
        bus(1'b1, 9'h1fc, 32'hffff_ffff);
        rd(9'h1fc, 32'h0);
        @(posedge mclk);
        ce <= 1'b0;
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
        $display("test reset done");
    endtask : t_reset
    task automatic t_out;
        logic [31:0] got;
        logic [3:0]  prev;
        int          n;
        int          s;
        got = 32'h0;
        s = 0;
        prev = 4'h0;
        n = 0;
        ev = 1'b0;
        bus(1'b1, 9'h040, 32'hb);
        bus(1'b1, 9'h044, 32'h8765_4321);
        repeat (60) begin
            @(negedge mclk);
            ev |= port_event[2];
            s += strobe_out[2];
            if (pad_out[3:0] !== prev && n < 8) begin
                got[4*n +: 4] = pad_out[3:0];
                prev = pad_out[3:0];
                n++;
            end
        end
        chk(got, 32'h8765_4321);
        chk(pad_oe[3:0], 4'hf);
        chk(ev, 1'b1);
        // one strobe cycle per nibble slice
        chk(s, 32'd8);
        $display("test out done");
    endtask : t_out
    task automatic t_oc;
        int n;
        n = 0;
        bus(1'b1, 9'h060, 32'h7);
        bus(1'b1, 9'h064, 32'h0000_00a5);
        while (pad_oe[7:4] !== 4'h5 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        chk(pad_oe[7:0], 8'h5f);
        chk(pad_out[7:0], 8'h08);
        bus(1'b1, 9'h060, 32'h0);
        bus(1'b1, 9'h040, 32'h0);
        $display("test open collector done");
    endtask : t_oc
    task automatic t_in;
        @(posedge mclk);
        drv <= 32'h1;
        bus(1'b1, 9'h000, 32'h9);
        wait_ev(0, 60);
        chk(ev, 1'b0);
        // pin 0 is high, so an equal-to-zero condition never starts a word
        bus(1'b1, 9'h000, 32'h21);
        wait_ev(0, 60);
        chk(ev, 1'b0);
        bus(1'b1, 9'h000, 32'h1);
        wait_ev(0, 60);
        chk(ev, 1'b1);
        bus(1'b0, 9'h000, 32'h0);
        chk(q & 32'h0002_0000, 32'h0002_0000);
        rd(9'h004, 32'hffff_ffff);
        bus(1'b0, 9'h000, 32'h0);
        chk(q & 32'h0002_0000, 32'h0);
        $display("test input done");
    endtask : t_in
    task automatic t_count;
        logic [31:0] cfg [3] = '{32'h001, 32'h101, 32'h601};
        logic [15:0] exp [3] = '{16'h000c, 16'h0003, 16'h0000};
        logic [15:0] c;
        bus(1'b1, 9'h104, 32'h0000_0300);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 9'h000, cfg[i]);
            bus(1'b0, 9'h00c, 32'h0);
            c = q[15:0];
            // twelve clocks between the two samples
            repeat (9) @(posedge mclk);
            bus(1'b0, 9'h00c, 32'h0);
            c = q[15:0] - c;
            chk({16'h0, c}, {16'h0, exp[i]});
        end
        bus(1'b1, 9'h000, 32'h0);
        @(posedge mclk);
        drv <= 32'h0;
        $display("test counter done");
    endtask : t_count
    task automatic t_link;
        logic [31:0] t;
        // first slice held until the counter meets the match value
        bus(1'b0, 9'h0ac, 32'h0);
        t = q + 32'h28;
        bus(1'b1, 9'h0a8, t);
        bus(1'b1, 9'h0a0, 32'h13);
        bus(1'b1, 9'h0a4, 32'h1234_5678);
        repeat (4) @(negedge mclk);
        chk(pad_out, 32'h0);
        repeat (40) @(negedge mclk);
        chk(pad_out, 32'h1234_5678);
        chk(pad_oe, 32'hffff_ffff);
        rd(9'h0b0, {16'h0, t[15:0]});
        bus(1'b1, 9'h140, 32'h1);
        repeat (2) @(negedge mclk);
        chk(pad_oe, 32'h00ff_ffff);
        chk(link_en, 1'b1);
        bus(1'b1, 9'h140, 32'h0);
        bus(1'b1, 9'h0a0, 32'h0);
        $display("test link done");
    endtask : t_link

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        // reset edge at time zero so no flop starts unknown
        reset_n <= 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_out();
        t_oc();
        t_in();
        t_count();
        t_link();
        end_of_test();
    end
endmodule : timed_io_port_test

bind timed_io_port tio_monitor i_tio_monitor (.mclk(mclk), .reset_n(reset_n), .ce(ce),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .strobe_in(strobe_in),
    .strobe_out(strobe_out), .port_event(port_event), .link_en(link_en));
